//--- core/ics_pkg.sv
// constants, register map and types of the input clock selector
// Function
// (RULE_01) exit bit 0 leaves holdover with fast-lock rate, 1 with normal loop rate
// (RULE_02) averaging window lasts (2^L - 1) x 8/3 x 1e-7 seconds
// (RULE_03) ignore delay before the window lasts 2^D x 2/3 x 1e-7 seconds
// (RULE_04) force bit enters holdover when history ready, else free-run; 0 is normal
// (RULE_05) switch mode: 0 manual, 1 automatic non-revertive, 2 revertive, 3 reserved
// (RULE_06) in manual mode source bit picks select pins (0) or register field (1)
// (RULE_07) register selection field value n selects input n, default input 0
// (RULE_08) select pins value n selects input n
// (RULE_09) with zero-delay operation input 3 is feedback, never a loop source
// (RULE_10) manual selection without valid clock enters holdover or free-run by itself
// (RULE_11) automatic mode ignores both select pins and register selection field
// (RULE_12) automatic choice only among unmasked-fault-free inputs; none gives holdover
// (RULE_13) revertive mode always moves to the highest-priority valid input
// (RULE_14) non-revertive mode keeps active input while valid, then takes best valid
// (RULE_15) no automatic switching while zero-delay operation is on
// (RULE_16) per-input signal loss ignore bit removes that loss from qualification
// (RULE_17) per-input frequency fault ignore bit removes that fault from qualification
// (RULE_18) rank 1 is most important down to 4; 0 never selected; 5-7 reserved
// (RULE_19) ranks sit at bits 2:0 and 6:4 of two consecutive bytes
// (RULE_20) history ready only after window plus delay of valid clock; loss restarts it
// (RULE_21) a valid input during holdover ends holdover and pulls in to it
// (RULE_22) equal nonzero ranks prefer the lower input index
package ics_pkg;
    localparam logic [15:0] ADDR_MANUAL_SEL = 16'h052A;
    localparam logic [15:0] ADDR_EXIT_RATE = 16'h052C;
    localparam logic [15:0] ADDR_WINDOW_LEN = 16'h052E;
    localparam logic [15:0] ADDR_IGNORE_DELAY = 16'h052F;
    localparam logic [15:0] ADDR_FORCE_HOLD = 16'h0535;
    localparam logic [15:0] ADDR_SWITCH_MODE = 16'h0536;
    localparam logic [15:0] ADDR_FAULT_MASKS = 16'h0537;
    localparam logic [15:0] ADDR_RANK_LOW = 16'h0538;
    localparam logic [15:0] ADDR_RANK_HIGH = 16'h0539;
    localparam logic [15:0] ADDR_HOLD_STATUS = 16'h053F;
    localparam int EXIT_RATE_BIT = 4;
    localparam int HIST_READY_BIT = 1;
    localparam int RANK_HI_LSB = 4;
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO_NONREV = 2'h1;
    localparam logic [1:0] MODE_AUTO_REV = 2'h2;
    localparam logic [2:0] RANK_NEVER = 3'h0;
    localparam logic [2:0] RANK_LOWEST = 3'h4;
    localparam logic [4:0] WINDOW_CODE_RST = 5'h0A;
    localparam logic [4:0] DELAY_CODE_RST = 5'h0A;
    localparam logic [15:0] RANKS_RST = 16'h4321;
    localparam int NUM_INPUTS = 4;
    localparam int FEEDBACK_INPUT = 3;
    // history time is counted in thirds of a nanosecond so both formulas stay exact
    localparam int HIST_CNT_W = 44;
    localparam logic [HIST_CNT_W-1:0] WINDOW_UNIT_NS3 = 44'h320;
    localparam logic [HIST_CNT_W-1:0] DELAY_UNIT_NS3 = 44'hC8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_STEP_NS3 = CLK_PERIOD_NS * 3;
    localparam int PULLIN_TIME_NS = 160;
    localparam int PULLIN_CYCLES = (PULLIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_FREERUN = 2'h0,
        ST_PULLIN = 2'h1,
        ST_LOCKED = 2'h3,
        ST_HOLDOVER = 2'h2
    } ics_state_t;
endpackage

//--- core/ics_links_if.sv
// interfaces between the selector core and its helpers
`timescale 1ns/1ns
interface ics_hist_if;
    logic run;
    logic [4:0] windowCode;
    logic [4:0] delayCode;
    logic ready;
    modport owner(output run, output windowCode, output delayCode, input ready);
    modport timer(input run, input windowCode, input delayCode, output ready);
endinterface

interface ics_pick_if;
    logic [3:0] qualified;
    logic [15:0] ranks;
    logic revertive;
    logic [1:0] current;
    logic [1:0] nextIdx;
    logic anyValid;
    modport owner(output qualified, output ranks, output revertive, output current,
                  input nextIdx, input anyValid);
    modport picker(input qualified, input ranks, input revertive, input current,
                   output nextIdx, output anyValid);
endinterface

//--- core/ics_auto_pick.sv
// automatic input choice from qualification and rank
`timescale 1ns/1ns
module ics_auto_pick (
    ics_pick_if.picker pick
);
    import ics_pkg::*;
    logic [NUM_INPUTS-1:0] eligible;
    logic [2:0] rankOf [NUM_INPUTS];
    logic [1:0] bestIdx;
    logic [2:0] bestRank;
    logic bestFound;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            assign rankOf[gi] = pick.ranks[gi*RANK_HI_LSB +: 3];
            // reserved ranks are treated like never-selected
            assign eligible[gi] = pick.qualified[gi] && (rankOf[gi] != RANK_NEVER)
                && (rankOf[gi] <= RANK_LOWEST); // RULE_12 RULE_18
        end
    endgenerate

    always_comb begin
        bestIdx = pick.current;
        bestRank = RANK_LOWEST;
        bestFound = 1'b0;
        // strict less-than keeps the lower index on a tie
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (eligible[i] && (!bestFound || rankOf[i] < bestRank)) begin // RULE_22
                bestIdx = 2'(i);
                bestRank = rankOf[i];
                bestFound = 1'b1;
            end
        end
    end

    wire keepCurrent = !pick.revertive && eligible[pick.current]; // RULE_14
    assign pick.nextIdx = keepCurrent ? pick.current : bestIdx; // RULE_13
    assign pick.anyValid = bestFound;
endmodule

//--- core/ics_history_timer.sv
// holdover history timer: window plus ignore delay of selected valid clock
`timescale 1ns/1ns
module ics_history_timer #(
    parameter int stepNs3 = ics_pkg::CLK_STEP_NS3
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    ics_hist_if.timer hist
);
    import ics_pkg::*;
    localparam logic [HIST_CNT_W-1:0] STEP = HIST_CNT_W'(stepNs3);
    logic [HIST_CNT_W-1:0] elapsed_r;
    logic ready_r;

    wire [HIST_CNT_W-1:0] windowNs3 =
        ((HIST_CNT_W'(1) << hist.windowCode) - HIST_CNT_W'(1)) * WINDOW_UNIT_NS3; // RULE_02
    wire [HIST_CNT_W-1:0] delayNs3 =
        (HIST_CNT_W'(1) << hist.delayCode) * DELAY_UNIT_NS3; // RULE_03
    wire [HIST_CNT_W-1:0] targetNs3 = windowNs3 + delayNs3;
    wire reached = elapsed_r >= targetNs3;

    always_ff @(posedge clk) begin
        if (sys_rst || !hist.run) begin
            elapsed_r <= '0; // RULE_20
            ready_r <= 1'b0;
        end else begin
            // counter saturates once the goal is met
            if (!reached) begin
                elapsed_r <= elapsed_r + STEP;
            end
            ready_r <= reached; // RULE_20
        end
    end

    assign hist.ready = ready_r;
endmodule

//--- core/ics_input_selector.sv
// input clock selector with manual and automatic switching and holdover control
`timescale 1ns/1ns
module ics_input_selector #(
    parameter int histStepNs3 = ics_pkg::CLK_STEP_NS3,
    parameter int pullInCycles = ics_pkg::PULLIN_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_r,
    // package select pins
    input wire logic [1:0] selectPins,
    // fault monitors and mode
    input wire logic [3:0] signalLoss,
    input wire logic [3:0] frequencyFault,
    input wire logic zeroDelayOperation,
    // loop control
    output logic [1:0] activeInput_r,
    output ics_pkg::ics_state_t loopState_r,
    output logic inHoldover_r,
    output logic inFreeRun_r,
    output logic pullInFast_r,
    output logic historyReady_r
);
    import ics_pkg::*;

    // configuration registers
    logic selectFromRegister_r;
    logic [1:0] regSelect_r;
    logic exitRateChoice_r;
    logic [4:0] averageWindowCode_r;
    logic [4:0] ignoreDelayCode_r;
    logic forceHold_r;
    logic [1:0] switchMode_r;
    logic [3:0] signalLossIgnore_r;
    logic [3:0] frequencyFaultIgnore_r;
    logic [15:0] ranks_r;

    // loop state
    ics_state_t state_nxt;
    logic [7:0] pullCnt_r;
    logic [7:0] rdMux;

    ics_hist_if histLink();
    ics_pick_if pickLink();

    // address decode
    wire wrSel = regWrEn && (regAddr == ADDR_MANUAL_SEL);
    wire wrExit = regWrEn && (regAddr == ADDR_EXIT_RATE);
    wire wrWindow = regWrEn && (regAddr == ADDR_WINDOW_LEN);
    wire wrDelay = regWrEn && (regAddr == ADDR_IGNORE_DELAY);
    wire wrForce = regWrEn && (regAddr == ADDR_FORCE_HOLD);
    wire wrMode = regWrEn && (regAddr == ADDR_SWITCH_MODE);
    wire wrMasks = regWrEn && (regAddr == ADDR_FAULT_MASKS);
    wire wrRankLo = regWrEn && (regAddr == ADDR_RANK_LOW);
    wire wrRankHi = regWrEn && (regAddr == ADDR_RANK_HIGH);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selectFromRegister_r <= 1'b0;
            regSelect_r <= 2'h0;
        end else if (wrSel) begin
            selectFromRegister_r <= regWrData[0]; // RULE_06
            regSelect_r <= regWrData[2:1]; // RULE_07
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exitRateChoice_r <= 1'b0;
        end else if (wrExit) begin
            exitRateChoice_r <= regWrData[EXIT_RATE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            averageWindowCode_r <= WINDOW_CODE_RST;
        end else if (wrWindow) begin
            averageWindowCode_r <= regWrData[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ignoreDelayCode_r <= DELAY_CODE_RST;
        end else if (wrDelay) begin
            ignoreDelayCode_r <= regWrData[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            forceHold_r <= 1'b0;
        end else if (wrForce) begin
            forceHold_r <= regWrData[0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            switchMode_r <= MODE_MANUAL;
        end else if (wrMode) begin
            switchMode_r <= regWrData[1:0]; // RULE_05
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            signalLossIgnore_r <= 4'h0;
            frequencyFaultIgnore_r <= 4'h0;
        end else if (wrMasks) begin
            signalLossIgnore_r <= regWrData[3:0]; // RULE_16
            frequencyFaultIgnore_r <= regWrData[7:4]; // RULE_17
        end
    end

    // two ranks per byte, at bits 2:0 and 6:4
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ranks_r <= RANKS_RST;
        end else begin
            if (wrRankLo) begin
                ranks_r[2:0] <= regWrData[2:0]; // RULE_19
                ranks_r[6:4] <= regWrData[6:4];
            end
            if (wrRankHi) begin
                ranks_r[10:8] <= regWrData[2:0]; // RULE_19
                ranks_r[14:12] <= regWrData[6:4];
            end
        end
    end

    // readback; reserved bits and unmapped addresses read zero
    always_comb begin
        rdMux = 8'h00;
        if (regAddr == ADDR_MANUAL_SEL) begin
            rdMux = {5'h00, regSelect_r, selectFromRegister_r};
        end else if (regAddr == ADDR_EXIT_RATE) begin
            rdMux[EXIT_RATE_BIT] = exitRateChoice_r;
        end else if (regAddr == ADDR_WINDOW_LEN) begin
            rdMux = {3'h0, averageWindowCode_r};
        end else if (regAddr == ADDR_IGNORE_DELAY) begin
            rdMux = {3'h0, ignoreDelayCode_r};
        end else if (regAddr == ADDR_FORCE_HOLD) begin
            rdMux = {7'h00, forceHold_r};
        end else if (regAddr == ADDR_SWITCH_MODE) begin
            rdMux = {6'h00, switchMode_r};
        end else if (regAddr == ADDR_FAULT_MASKS) begin
            rdMux = {frequencyFaultIgnore_r, signalLossIgnore_r};
        end else if (regAddr == ADDR_RANK_LOW) begin
            rdMux = {1'b0, ranks_r[6:4], 1'b0, ranks_r[2:0]};
        end else if (regAddr == ADDR_RANK_HIGH) begin
            rdMux = {1'b0, ranks_r[14:12], 1'b0, ranks_r[10:8]};
        end else if (regAddr == ADDR_HOLD_STATUS) begin
            rdMux[HIST_READY_BIT] = historyReady_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData_r <= 8'h00;
        end else if (regRdEn) begin
            regRdData_r <= rdMux;
        end
    end

    // input qualification
    // feedback input drops out of every choice in zero-delay operation
    wire [3:0] usable = {~zeroDelayOperation, 3'h7}; // RULE_09
    wire [3:0] lossCounts = signalLoss & ~signalLossIgnore_r; // RULE_16
    wire [3:0] faultCounts = frequencyFault & ~frequencyFaultIgnore_r; // RULE_17
    wire [3:0] qualified = ~(lossCounts | faultCounts) & usable; // RULE_12
    // manual validity ignores the masks: they only steer automatic switching
    wire [3:0] clockPresent = ~(signalLoss | frequencyFault) & usable;

    // reserved mode code behaves as manual
    wire autoMode = (switchMode_r == MODE_AUTO_NONREV) || (switchMode_r == MODE_AUTO_REV);
    wire [1:0] manualPick = selectFromRegister_r ? regSelect_r : selectPins; // RULE_06 RULE_08

    assign pickLink.qualified = qualified;
    assign pickLink.ranks = ranks_r;
    assign pickLink.revertive = (switchMode_r == MODE_AUTO_REV); // RULE_13
    assign pickLink.current = activeInput_r;

    ics_auto_pick uPick (
        .pick(pickLink.picker)
    );

    // automatic mode never looks at pins or the register field
    // zero-delay operation freezes the automatic choice on the present input
    wire [1:0] autoIdx = zeroDelayOperation ? activeInput_r : pickLink.nextIdx; // RULE_11 RULE_15
    wire autoValid = zeroDelayOperation ? qualified[activeInput_r] : pickLink.anyValid;
    wire [1:0] candidateIdx = autoMode ? autoIdx : manualPick;
    wire candidateValid = autoMode ? autoValid : clockPresent[manualPick]; // RULE_10 RULE_12
    wire switchEvent = candidateIdx != activeInput_r;
    wire sourceOk = candidateValid && !forceHold_r; // RULE_04

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            activeInput_r <= 2'h0;
        end else begin
            activeInput_r <= candidateIdx;
        end
    end

    // history runs only while a valid clock feeds the loop unchanged
    assign histLink.run = sourceOk && !switchEvent
        && (loopState_r == ST_PULLIN || loopState_r == ST_LOCKED); // RULE_20
    assign histLink.windowCode = averageWindowCode_r;
    assign histLink.delayCode = ignoreDelayCode_r;

    ics_history_timer #(
        .stepNs3(histStepNs3)
    ) uHist (
        .clk(clk),
        .sys_rst(sys_rst),
        .hist(histLink.timer)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            historyReady_r <= 1'b0;
        end else begin
            historyReady_r <= histLink.ready;
        end
    end

    wire pullDone = pullCnt_r >= 8'(pullInCycles - 1);
    // leaving lock uses the history gathered so far
    wire ics_state_t lossState = historyReady_r ? ST_HOLDOVER : ST_FREERUN; // RULE_04 RULE_10

    always_comb begin
        state_nxt = loopState_r;
        case (loopState_r)
            ST_FREERUN: begin
                if (sourceOk) begin
                    state_nxt = ST_PULLIN;
                end
            end
            ST_PULLIN: begin
                if (!sourceOk) begin
                    state_nxt = lossState;
                end else if (pullDone && !switchEvent) begin
                    state_nxt = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (!sourceOk) begin
                    state_nxt = lossState; // RULE_12
                end else if (switchEvent) begin
                    state_nxt = ST_PULLIN;
                end
            end
            ST_HOLDOVER: begin
                if (sourceOk) begin
                    state_nxt = ST_PULLIN; // RULE_21
                end
            end
            default: begin
                state_nxt = ST_FREERUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loopState_r <= ST_FREERUN;
        end else begin
            loopState_r <= state_nxt;
        end
    end

    // pull-in counter restarts on every entry and on every switchover
    always_ff @(posedge clk) begin
        if (sys_rst || state_nxt != ST_PULLIN || loopState_r != ST_PULLIN || switchEvent) begin
            pullCnt_r <= 8'h00;
        end else if (!pullDone) begin
            pullCnt_r <= pullCnt_r + 8'h01;
        end
    end

    // the fast rate applies only to a pull-in that leaves holdover or free-run
    wire leavingHold = (loopState_r == ST_HOLDOVER || loopState_r == ST_FREERUN)
        && state_nxt == ST_PULLIN;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullInFast_r <= 1'b0;
        end else if (leavingHold) begin
            pullInFast_r <= !exitRateChoice_r; // RULE_01
        end else if (state_nxt != ST_PULLIN || switchEvent) begin
            pullInFast_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            inHoldover_r <= 1'b0;
            inFreeRun_r <= 1'b1;
        end else begin
            inHoldover_r <= state_nxt == ST_HOLDOVER; // RULE_04
            inFreeRun_r <= state_nxt == ST_FREERUN;
        end
    end
endmodule

//--- verif/ics_selector_props.sv
// concurrent checks on the input clock selector ports
`timescale 1ns/1ns
module ics_selector_props (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_r,
    // pins and mode
    input wire logic [1:0] selectPins,
    input wire logic zeroDelayOperation,
    // loop control
    input wire logic [1:0] activeInput_r,
    input wire ics_pkg::ics_state_t loopState_r,
    input wire logic inHoldover_r,
    input wire logic inFreeRun_r,
    input wire logic pullInFast_r,
    input wire logic historyReady_r
);
    import ics_pkg::*;
    // shadow copies of the few control fields, tracked from the write strobe
    logic [1:0] modeSh_r;
    logic [2:0] selSh_r;
    logic exitSh_r;
    logic forceSh_r;
    wire logic [1:0] regSel = selSh_r[2:1];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeSh_r <= 2'h0;
            selSh_r <= 3'h0;
            exitSh_r <= 1'h0;
            forceSh_r <= 1'h0;
        end else if (regWrEn) begin
            if (regAddr == ADDR_SWITCH_MODE) modeSh_r <= regWrData[1:0];
            if (regAddr == ADDR_MANUAL_SEL) selSh_r <= regWrData[2:0];
            if (regAddr == ADDR_EXIT_RATE) exitSh_r <= regWrData[EXIT_RATE_BIT];
            if (regAddr == ADDR_FORCE_HOLD) forceSh_r <= regWrData[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_holdover_flag: assert property (
        inHoldover_r == (loopState_r == ST_HOLDOVER)) else $error("holdover flag wrong");
    a_freerun_flag: assert property (
        inFreeRun_r == (loopState_r == ST_FREERUN)) else $error("free-run flag wrong");
    a_force_leaves_lock: assert property (
        forceSh_r |=> loopState_r == ST_HOLDOVER || loopState_r == ST_FREERUN)
        else $error("forced hold not entered");
    a_pin_select: assert property (
        modeSh_r == MODE_MANUAL && !selSh_r[0] && !zeroDelayOperation
        |=> activeInput_r == $past(selectPins)) else $error("pin selection wrong");
    a_reg_select: assert property (
        modeSh_r == MODE_MANUAL && selSh_r[0] && !zeroDelayOperation
        |=> activeInput_r == $past(regSel)) else $error("register selection wrong");
    a_mode_readback: assert property (
        regRdEn && regAddr == ADDR_SWITCH_MODE |=> regRdData_r == {6'h00, $past(modeSh_r)})
        else $error("mode field readback wrong");
    a_exit_rate_choice: assert property (
        loopState_r == ST_PULLIN
        && ($past(loopState_r) == ST_FREERUN || $past(loopState_r) == ST_HOLDOVER)
        |-> pullInFast_r == !$past(exitSh_r)) else $error("exit rate wrong");
    a_locked_not_fast: assert property (
        loopState_r == ST_LOCKED |-> !pullInFast_r) else $error("fast rate while locked");
    a_hold_needs_hist: assert property (
        $rose(inHoldover_r) |-> $past(historyReady_r)) else $error("holdover without history");
    a_feedback_not_src: assert property (
        zeroDelayOperation && $past(zeroDelayOperation)
        |-> !(activeInput_r == 2'h3 && (loopState_r == ST_LOCKED || loopState_r == ST_PULLIN)))
        else $error("feedback input used as source");
    c_fast_pullin: cover property (loopState_r == ST_PULLIN && pullInFast_r);
    c_holdover: cover property (inHoldover_r);
    c_auto_switch: cover property (modeSh_r == MODE_AUTO_REV && $changed(activeInput_r));
endmodule

bind ics_input_selector ics_selector_props chk (
    .clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData_r(regRdData_r),
    .selectPins(selectPins), .zeroDelayOperation(zeroDelayOperation),
    .activeInput_r(activeInput_r), .loopState_r(loopState_r), .inHoldover_r(inHoldover_r),
    .inFreeRun_r(inFreeRun_r), .pullInFast_r(pullInFast_r), .historyReady_r(historyReady_r)
);

//--- verif/test_input_clock_selector.sv
// self-checking bench for the input clock selector
`timescale 1ns/1ns
module test_input_clock_selector;
    import ics_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic [1:0] selectPins = 2'h0;
    logic [3:0] signalLoss = 4'h0;
    logic [3:0] frequencyFault = 4'h0;
    logic zeroDelayOperation = 1'b0;
    logic [7:0] regRdData_r;
    logic [1:0] activeInput_r;
    ics_state_t loopState_r;
    logic inHoldover_r, inFreeRun_r, pullInFast_r, historyReady_r;
    int err_total = 0;
    int n_tests = 0;
    logic [15:0] tabAddr [11] = '{16'h052A, 16'h052C, 16'h052E, 16'h052F, 16'h0535,
        16'h0536, 16'h0537, 16'h0538, 16'h0539, 16'h053F, 16'h0540};
    logic [7:0] tabVal [11] = '{8'h00, 8'h00, 8'h0A, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h21,
        8'h43, 8'h00, 8'h00};

    ics_input_selector uut (
        .clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData_r(regRdData_r),
        .selectPins(selectPins), .signalLoss(signalLoss), .frequencyFault(frequencyFault),
        .zeroDelayOperation(zeroDelayOperation), .activeInput_r(activeInput_r),
        .loopState_r(loopState_r), .inHoldover_r(inHoldover_r), .inFreeRun_r(inFreeRun_r),
        .pullInFast_r(pullInFast_r), .historyReady_r(historyReady_r)
    );

    always #5 clk = ~clk;

    task automatic test_done;
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // every task leaves the bench 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        cyc(1);
        regWrEn = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        regRdEn = 1'b1;
        regAddr = a;
        cyc(1);
        regRdEn = 1'b0;
        chk(regRdData_r, exp);
        cyc(1);
    endtask
    task automatic waitSt(input ics_state_t s);
        int k = 0;
        while (loopState_r !== s && k < 100) begin
            cyc(1);
            k++;
        end
        chk({6'h00, loopState_r}, {6'h00, s});
    endtask
    // address 0 is unmapped, so a step without a register change still writes there
    task automatic step(input logic [15:0] a, input logic [7:0] d, input logic [3:0] signal_loss,
            input logic [3:0] frequency_fault, input logic [1:0] exp);
        wr(a, d);
        signalLoss = signal_loss;
        frequencyFault = frequency_fault;
        cyc(4);
        chk({6'h00, activeInput_r}, {6'h00, exp});
    endtask

    initial begin
        cyc(20);
        sys_rst = 1'b0;
        for (int i = 0; i < 11; i++) rd(tabAddr[i], tabVal[i]);
        wr(16'h052A, 8'hFF);
        rd(16'h052A, 8'h07);
        wr(16'h052A, 8'h00);
        for (int i = 0; i < 4; i++) begin
            selectPins = 2'(i);
            cyc(4);
            chk({6'h00, activeInput_r}, 8'(i));
        end
        selectPins = 2'h0;
        for (int e = 0; e < 2; e++) begin
            wr(16'h052C, 8'(e << 4));
            waitSt(ST_LOCKED);
            signalLoss = 4'h1;
            waitSt(ST_FREERUN);
            signalLoss = 4'h0;
            waitSt(ST_PULLIN);
            chk({7'h00, pullInFast_r}, 8'(e == 0));
        end
        for (int i = 0; i < 4; i++) begin
            selectPins = 2'(3 - i);
            wr(16'h052A, 8'((i << 1) | 1));
            cyc(4);
            chk({6'h00, activeInput_r}, 8'(i));
        end
        zeroDelayOperation = 1'b1;
        waitSt(ST_FREERUN);
        zeroDelayOperation = 1'b0;
        // shortest window and delay keep the history wait to a few cycles
        wr(16'h052E, 8'h00);
        wr(16'h052F, 8'h00);
        wr(16'h052A, 8'h01);
        waitSt(ST_LOCKED);
        cyc(20);
        chk({7'h00, historyReady_r}, 8'h01);
        rd(16'h053F, 8'h02);
        signalLoss = 4'h1;
        waitSt(ST_HOLDOVER);
        cyc(3);
        chk({7'h00, historyReady_r}, 8'h00);
        signalLoss = 4'h0;
        waitSt(ST_LOCKED);
        cyc(20);
        wr(16'h0535, 8'h01);
        waitSt(ST_HOLDOVER);
        wr(16'h0535, 8'h00);
        waitSt(ST_PULLIN);
        wr(16'h0535, 8'h01);
        waitSt(ST_FREERUN);
        wr(16'h0535, 8'h00);
        selectPins = 2'h2;
        step(16'h0536, 8'h02, 4'h0, 4'h0, 2'h0);
        step(16'h052A, 8'h07, 4'h0, 4'h0, 2'h0);
        step(16'h0000, 8'h00, 4'h1, 4'h0, 2'h1);
        step(16'h0000, 8'h00, 4'h0, 4'h0, 2'h0);
        step(16'h0537, 8'h01, 4'h1, 4'h0, 2'h0);
        step(16'h0537, 8'h10, 4'h0, 4'h1, 2'h0);
        step(16'h0537, 8'h00, 4'h0, 4'h1, 2'h1);
        step(16'h0538, 8'h11, 4'h0, 4'h0, 2'h0);
        step(16'h0538, 8'h30, 4'h0, 4'h0, 2'h1);
        step(16'h0539, 8'h14, 4'h0, 4'h0, 2'h3);
        step(16'h0539, 8'h05, 4'h0, 4'h0, 2'h1);
        step(16'h0538, 8'h21, 4'h0, 4'h0, 2'h0);
        step(16'h0539, 8'h43, 4'h0, 4'h0, 2'h0);
        step(16'h0536, 8'h01, 4'h1, 4'h0, 2'h1);
        step(16'h0000, 8'h00, 4'h0, 4'h0, 2'h1);
        step(16'h0000, 8'h00, 4'h2, 4'h0, 2'h0);
        signalLoss = 4'hF;
        cyc(4);
        chk({7'h00, inHoldover_r | inFreeRun_r}, 8'h01);
        step(16'h0000, 8'h00, 4'h0, 4'h0, 2'h0);
        zeroDelayOperation = 1'b1;
        step(16'h0000, 8'h00, 4'h1, 4'h0, 2'h0);
        zeroDelayOperation = 1'b0;
        test_done();
    end

    // the sequence needs a few hundred cycles; this allows about fifty thousand
    initial begin
        #500000;
        err_total++;
        test_done();
    end
endmodule
